// ---- logic/afd_fault_pin_out.sv ----
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R01: Headroom below 1.6 V: fast mute first, then discharge ripple and reference nodes.
// R02: After discharge restart only above low-supply mute threshold, else outputs low.
// R03: Bus mode supply below reset sets power-on flag; amps wait for start.
// R04: Standby pin low forces fast mute.
// R05: Supply above 22 V puts output stage into high impedance.
// R06: Warning level select bit, default 145 C; warning on fault pin, readable.
// R07: Legacy mode fixes warning at 145 C.
// R08: Above warning reduce gain on all channels; at shutdown switch all off.
// R09: Fault pin is OR of fixed sources and enabled selectable sources.
// R10: Fault pin low while failure persists, released when removed.
// R11: One clip level for all; each channel clip routed to fault or standby.
// R12: Bus mode fault pin low after reset until started; standby never shows it.
// R13: Legacy mode fault pin reports battery, clip, warning, shorts, missing, overvoltage.
// R14: Bus mode battery and overvoltage always; others enableable; only clip on standby.
// R15: Offset read sets latches; in-window clears them and blocks setting.
// R16: DC load detect enabled applies offset during start-up and classifies loads.
// R17: Load bits: 00 normal, 10 line driver, 11 open, 01 invalid.
// R18: AC enabled shows AC result in low bit; disabled restores stored DC bit.
// R19: AC load detection runs only after start-up completes.
// R20: AC bit sets only after three peak detector hits.
// R21: Host changes gain only while muted.
// R22: Result latches set on failure, cleared by read; read twice for current.
// R23: Start bit starts amp, clears power-on flag, releases fault pin.
// R24: Temperature and load-fault select bits zero route, one exclude.
// R25: Fault pin is open drain, driven low on any enabled fault.
module afd_fault_pin_out
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog sense and pins (asynchronous)
	input wire afd_pkg::afd_sense_s sense_in,
	input wire logic standby_pin_in,
	// Pins and drives
	output logic fault_pin_out,
	output logic fault_pin_oe,
	output logic standby_pin_out,
	output logic standby_pin_oe,
	output afd_pkg::afd_drive_s drive
);
	import afd_pkg::*;

	typedef struct packed
	{
		afd_sense_s s1;
		afd_sense_s s2;
		logic stb1;
		logic stb2;
		afd_state_e st;
		logic [15:0] cnt;
		logic [31:0] ctrl;
		logic [31:0] cfg;
		logic por_occurred_flag;
		logic [3:0] offset_flag;
		logic [3:0] peak_prev;
		logic [3:0] dc_hi;
		logic [3:0] dc_lo;
		logic [3:0] ac_res;
		logic [7:0] ac_cnt;
		logic warn_lat;
		logic [3:0] short_lat;
		logic [3:0] miss_lat;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic fault;
		logic stb_clip;
		afd_drive_s drv;
	} afd_regs_s;

	afd_regs_s r;
	afd_regs_s next_r;
	logic legacy;
	logic warn;
	logic [3:0] clip_stb;
	logic [3:0] in_win;

	// ==========================================================
	// Combinational next state
	always_comb
	begin
		next_r = r;
		// Two-flop synchronisers; only stage two is read
		next_r.s1 = sense_in;
		next_r.s2 = r.s1;
		next_r.stb1 = standby_pin_in;
		next_r.stb2 = r.stb1;
		legacy = r.cfg[CFG_LEGACY];
		clip_stb = legacy ? 4'h0 : r.ctrl[CTRL_CLIPSTB +: 4]; // R11
		in_win = r.s2.in_window;
		// Legacy pins warning at the 145 C detector
		warn = (legacy || !r.cfg[CFG_WARN_SEL]) ? r.s2.warn_lo // R07
			: r.s2.warn_hi; // R06

		// Sequencer
		next_r.cnt = (r.cnt != 16'h0000) ? r.cnt - 16'h0001 : 16'h0000;
		case (r.st)
			AFD_OFF:
			begin
				if (legacy || r.ctrl[CTRL_START]) // R23
				begin
					next_r.st = AFD_STARTUP;
				end
			end
			AFD_STARTUP:
			begin
				if (r.s2.startup_done)
				begin
					next_r.st = AFD_RUN;
				end
			end
			AFD_RUN:
			begin
				if (r.s2.headroom_low) // R01
				begin
					next_r.st = AFD_MUTE;
					next_r.cnt = 16'(DISCH_CYC);
				end
			end
			AFD_MUTE:
			begin
				// Mute must settle before the nodes are dumped
				if (r.cnt == 16'h0000) // R01
				begin
					next_r.st = AFD_DISCH;
				end
			end
			AFD_DISCH:
			begin
				if (r.s2.disch_done)
				begin
					next_r.st = r.s2.vp_below_mute ? AFD_LOW // R02
						: AFD_STARTUP;
				end
			end
			AFD_LOW:
			begin
				if (!r.s2.vp_below_mute) // R02
				begin
					next_r.st = AFD_STARTUP;
				end
			end
			default:
			begin
				next_r.st = AFD_OFF;
			end
		endcase
		// Supply collapse: bus mode waits for a fresh start
		if (r.s2.vp_below_reset)
		begin
			next_r.st = AFD_OFF; // R03
		end
		if (r.s2.temp_off)
		begin
			next_r.st = AFD_OFF; // R08
		end

		// Drives toward the analog stages
		next_r.drv.fast_mute = !r.stb2 || r.cfg[CFG_FMUTE] // R04
			|| next_r.st == AFD_MUTE || next_r.st == AFD_DISCH; // R01
		next_r.drv.discharge = next_r.st == AFD_DISCH; // R01
		next_r.drv.amp_on = next_r.st == AFD_STARTUP
			|| next_r.st == AFD_RUN || next_r.st == AFD_MUTE;
		next_r.drv.out_hiz = r.s2.vp_over; // R05
		next_r.drv.gain_reduce = warn; // R08
		next_r.drv.dc_probe = !legacy && r.ctrl[CTRL_DCLD]
			&& next_r.st == AFD_STARTUP; // R16

		// DC load classification captured at end of start-up
		if (r.drv.dc_probe && r.s2.startup_done)
		begin
			next_r.dc_hi = r.s2.dc_hi; // R16 R17
			next_r.dc_lo = r.s2.dc_lo; // R17
		end

		// AC detect only after start-up; three hits to set
		// Hits are rising edges, so a long pulse counts once
		next_r.peak_prev = r.s2.peak_hit;
		for (int i = 0; i < 4; i++)
		begin
			if (!r.ctrl[CTRL_ACLD] || r.st != AFD_RUN) // R19
			begin
				next_r.ac_cnt[2*i +: 2] = 2'b00;
			end
			else if (r.s2.peak_hit[i] && !r.peak_prev[i]
				&& r.ac_cnt[2*i +: 2] != 2'(AC_HITS))
			begin
				next_r.ac_cnt[2*i +: 2] = r.ac_cnt[2*i +: 2] + 2'b01; // R20
			end
			if (!r.ctrl[CTRL_ACLD])
			begin
				next_r.ac_res[i] = 1'b0;
			end
			else if (next_r.ac_cnt[2*i +: 2] == 2'(AC_HITS))
			begin
				next_r.ac_res[i] = 1'b1; // R20
			end
			// Offset: in-window clears and blocks until next read
			if (in_win[i])
			begin
				next_r.offset_flag[i] = 1'b0; // R15
			end
		end

		// Sticky latches; set beats the read clear below
		// ==========================================================
		// AXI4-Lite slave
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_r.aw_got = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.aw_got && r.w_got && !r.bvalid)
		begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = AXI_OKAY;
			case (r.awaddr)
				CTRL_ADDR:
				begin
					for (int b = 0; b < 4; b++)
					begin
						if (r.wstrb[b])
						begin
							next_r.ctrl[8*b +: 8] = r.wdata[8*b +: 8];
						end
					end
					if (r.wstrb[0] && r.wdata[CTRL_START])
					begin
						next_r.por_occurred_flag = 1'b0; // R23
					end
				end
				CFG_ADDR:
				begin
					for (int b = 0; b < 4; b++)
					begin
						if (r.wstrb[b])
						begin
							next_r.cfg[8*b +: 8] = r.wdata[8*b +: 8];
						end
					end
				end
				default:
				begin
					next_r.bresp = AXI_SLVERR;
				end
			endcase
		end
		else if (r.bvalid && s_axi_bready)
		begin
			next_r.bvalid = 1'b0;
		end
		// Reads clear the result latches they return
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp = AXI_OKAY;
			next_r.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				CTRL_ADDR:
				begin
					next_r.rdata = r.ctrl;
				end
				CFG_ADDR:
				begin
					next_r.rdata = r.cfg;
				end
				STAT_ADDR:
				begin
					next_r.rdata = {21'h0, r.st, r.warn_lat,
						r.s2.vp_over, r.s2.vp_below_mute,
						r.por_occurred_flag, 4'h0};
					next_r.warn_lat = 1'b0; // R22
				end
				CHAN_ADDR:
				begin
					for (int i = 0; i < 4; i++)
					begin
						// Low load bit shows AC result while AC enabled
						next_r.rdata[8*i +: 8] = {2'b00, r.dc_hi[i],
							r.ctrl[CTRL_ACLD] ? r.ac_res[i] // R18
							: r.dc_lo[i], // R17
							r.short_lat[i], r.offset_flag[i],
							r.miss_lat[i], 1'b0};
						// Offset read arms the latch unless in window
						next_r.offset_flag[i] = !in_win[i]; // R15
					end
					next_r.short_lat = 4'h0; // R22
					next_r.miss_lat = 4'h0; // R22
				end
				default:
				begin
					next_r.rresp = AXI_SLVERR;
				end
			endcase
		end
		else if (r.rvalid && s_axi_rready)
		begin
			next_r.rvalid = 1'b0;
		end
		// Set wins over read clear
		next_r.warn_lat = next_r.warn_lat | warn; // R22
		next_r.short_lat = next_r.short_lat | r.s2.short_flt; // R22
		next_r.miss_lat = next_r.miss_lat | r.s2.miss_cur; // R22
		// Supply collapse beats a start write in the same cycle
		if (r.s2.vp_below_reset && !legacy)
		begin
			next_r.por_occurred_flag = 1'b1; // R03
			next_r.ctrl[CTRL_START] = 1'b0; // R03
		end

		// ==========================================================
		// Fault pin: fixed sources plus enabled ones, live state
		next_r.fault = r.s2.vp_below_mute || r.s2.vp_over // R09 R14
			|| (!legacy && (r.por_occurred_flag // R12
			|| !r.ctrl[CTRL_START])) // R23
			|| ((legacy || !r.cfg[CFG_TEMP_EXCL]) && warn) // R24 R13
			|| ((legacy || !r.cfg[CFG_LOAD_EXCL]) // R24
			&& (|(r.s2.short_flt | r.s2.miss_cur))) // R13
			|| (|(r.s2.clip & ~clip_stb)); // R11 R10
		next_r.stb_clip = !legacy && (|(r.s2.clip & clip_stb)); // R14
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.stb1 <= 1'b1;
			r.stb2 <= 1'b1;
			r.ctrl <= CTRL_RESET;
			r.cfg <= CFG_RESET;
			r.st <= AFD_OFF;
			r.por_occurred_flag <= 1'b1;
			r.fault <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// Handshakes: one write and one read in flight at a time
	assign s_axi_awready = !r.aw_got && !r.bvalid;
	assign s_axi_wready = !r.w_got && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	// Open drain: only ever pulls low
	assign fault_pin_out = 1'b0; // R25
	assign fault_pin_oe = r.fault; // R25
	assign standby_pin_out = 1'b0;
	assign standby_pin_oe = r.stb_clip; // R12
	assign drive = r.drv;

	// ==========================================================
	// Checks
	sequence seq_headroom;
		r.st == AFD_RUN && r.s2.headroom_low && !r.s2.vp_below_reset
			&& !r.s2.temp_off;
	endsequence
	AST_HEADROOM_MUTE: assert property (@(posedge aclk) disable iff (!aresetn) // R01
		seq_headroom |=> drive.fast_mute && !drive.discharge)
		else $error("headroom did not mute before discharge");
	AST_RESTART_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R02
		r.st == AFD_DISCH && r.s2.disch_done && r.s2.vp_below_mute
		&& !r.s2.vp_below_reset && !r.s2.temp_off |=> r.st == AFD_LOW)
		else $error("restart below low-supply threshold");
	AST_POR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // R03
		r.s2.vp_below_reset && !legacy |=> r.por_occurred_flag
		&& r.st == AFD_OFF)
		else $error("power-on flag not set");
	AST_STB_MUTE: assert property (@(posedge aclk) disable iff (!aresetn) // R04
		!r.stb2 |=> drive.fast_mute)
		else $error("standby low without fast mute");
	AST_OVERV: assert property (@(posedge aclk) disable iff (!aresetn) // R05
		r.s2.vp_over |=> drive.out_hiz && fault_pin_oe)
		else $error("overvoltage not handled");
	AST_TOFF: assert property (@(posedge aclk) disable iff (!aresetn) // R08
		r.s2.temp_off |=> !drive.amp_on)
		else $error("amplifier on above shutdown temperature");
	AST_NOSTART: assert property (@(posedge aclk) disable iff (!aresetn) // R23
		!legacy && !r.ctrl[CTRL_START] |=> fault_pin_oe)
		else $error("fault pin released before start");
	AST_AC_THREE: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		$rose(r.ac_res[0]) |-> r.ac_cnt[1:0] == 2'(AC_HITS))
		else $error("ac result set before three hits");
	AST_OFS_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		in_win[0] && !(s_axi_arvalid && s_axi_arready) |=> !r.offset_flag[0])
		else $error("offset latch not cleared in window");
endmodule

// ---- logic/afd_pkg.sv ----
package afd_pkg;
	// ==========================================================
	// Register map (byte addresses, our own placement)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CFG_ADDR = 8'h04;
	localparam logic [7:0] STAT_ADDR = 8'h08;
	localparam logic [7:0] CHAN_ADDR = 8'h0c;
	// ==========================================================
	// Control and config register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_DCLD = 1;
	localparam int CTRL_ACLD = 2;
	localparam int CTRL_CLIPSTB = 3; // 4 bits: 3..6, one per channel
	localparam int CFG_TEMP_EXCL = 5;
	localparam int CFG_LOAD_EXCL = 4;
	localparam int CFG_WARN_SEL = 8;
	localparam int CFG_LEGACY = 9;
	localparam int CFG_FMUTE = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int DISCH_US = 10;
	localparam int DISCH_CYC = DISCH_US * CLK_MHZ;
	localparam int AC_HITS = 3;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		AFD_OFF = 3'b000,
		AFD_STARTUP = 3'b001,
		AFD_RUN = 3'b010,
		AFD_MUTE = 3'b011,
		AFD_DISCH = 3'b100,
		AFD_LOW = 3'b101
	} afd_state_e;
	// Analog comparator and detector inputs, one bit per event
	typedef struct packed
	{
		logic headroom_low;
		logic vp_below_mute;
		logic vp_below_reset;
		logic vp_over;
		logic warn_hi;
		logic warn_lo;
		logic temp_off;
		logic [3:0] clip;
		logic [3:0] short_flt;
		logic [3:0] miss_cur;
		logic [3:0] in_window;
		logic [3:0] peak_hit;
		logic [3:0] dc_hi;
		logic [3:0] dc_lo;
		logic startup_done;
		logic disch_done;
	} afd_sense_s;
	// Drive outputs toward the analog stages
	typedef struct packed
	{
		logic fast_mute;
		logic discharge;
		logic amp_on;
		logic out_hiz;
		logic gain_reduce;
		logic dc_probe;
	} afd_drive_s;
endpackage

// ---- testbench/afd_sense_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Analog front end: comparator levels and peak detector
module afd_sense_model
(
	// Requested levels
	input wire afd_pkg::afd_sense_s level_req,
	// Peak detector burst control
	input wire logic [3:0] burst,
	input wire logic go,
	// Toward the block
	output afd_pkg::afd_sense_s sense
);
	import afd_pkg::*;
	logic lclk;
	int n;
	initial lclk = 1'b0;
	// Link clock runs only inside a burst, still between bursts
	always @(posedge go)
	begin
		for (n = 0; n < burst; n++)
		begin
			#24 lclk = 1'b1;
			#24 lclk = 1'b0;
		end
	end
	// Channel 0 peak detector fires once per link clock period
	always_comb
	begin
		sense = level_req;
		sense.peak_hit[0] = lclk;
	end
endmodule

// ---- testbench/afd_fault_pin_out_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module afd_fault_pin_out_tb;
	import afd_pkg::*;
	// ==========================================================
	// Signals
	logic aclk, aresetn, go, standby_pin_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, burst;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic fault_pin_out, fault_pin_oe, standby_pin_out, standby_pin_oe;
	afd_sense_s lv, sense;
	afd_drive_s drive;
	int fails, checks, i;
	// ==========================================================
	// Instances
	afd_fault_pin_out afd_fault_pin_out_i
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.sense_in(sense),
		.standby_pin_in(standby_pin_in),
		.fault_pin_out(fault_pin_out),
		.fault_pin_oe(fault_pin_oe),
		.standby_pin_out(standby_pin_out),
		.standby_pin_oe(standby_pin_oe),
		.drive(drive)
	);
	afd_sense_model afd_sense_model_i
	(
		.level_req(lv),
		.burst(burst),
		.go(go),
		.sense(sense)
	);
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	// ==========================================================
	// Bus tasks: readiness judged mid-cycle, so no edge race
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic haw, hw, hb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Waits until bvalid is seen; only the watchdog ends a wait that never sees it
		forever
		begin
			@(negedge aclk);
			haw = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			r = hb ? s_axi_bresp : 2'bxx;
			@(posedge aclk);
			if (haw)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			if (hb)
				break;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic har, hr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(negedge aclk);
			har = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			d = hr ? s_axi_rdata : 32'hx;
			r = hr ? s_axi_rresp : 2'bxx;
			@(posedge aclk);
			if (har)
				s_axi_arvalid <= 1'b0;
			if (hr)
				break;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Sync plus pin latency is a few cycles; ten leaves margin
	// Ends on a rising edge: outputs have long been steady there
	task settle;
		repeat (10) @(posedge aclk);
	endtask
	task pulse(input int n);
		@(posedge aclk);
		burst <= 4'(n);
		go <= 1'b1;
		repeat (12 * n + 20) @(posedge aclk);
		go <= 1'b0;
	endtask
	task close_out;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		`CHK({fault_pin_oe, standby_pin_oe}, 2'b10)
		`CHK({fault_pin_out, standby_pin_out}, 2'b00)
		axi_rd(STAT_ADDR, rd, resp);
		`CHK(rd[4], 1'b1)
		axi_rd(CTRL_ADDR, rd, resp);
		`CHK(rd, CTRL_RESET)
		axi_rd(CFG_ADDR, rd, resp);
		`CHK(rd, CFG_RESET)
		axi_wr(8'h20, 32'h1, resp);
		`CHK(resp, AXI_SLVERR)
		axi_rd(8'h20, rd, resp);
		`CHK(resp, AXI_SLVERR)
	endtask
	// Open load on channel 0, measured during a held start-up
	task t_start;
		lv.startup_done <= 1'b0;
		lv.dc_hi <= 4'h1;
		lv.dc_lo <= 4'h1;
		axi_wr(CTRL_ADDR, 32'h3, resp);
		settle();
		`CHK(drive.dc_probe, 1'b1)
		lv.startup_done <= 1'b1;
		settle();
		`CHK(fault_pin_oe, 1'b0)
		`CHK({drive.amp_on, drive.fast_mute}, 2'b10)
		`CHK(drive.dc_probe, 1'b0)
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[5:4], 2'b11)
		axi_rd(STAT_ADDR, rd, resp);
		`CHK(rd[4], 1'b0)
	endtask
	// Armed by the read above; a window crossing clears channel 0
	task t_ofs;
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[2], 1'b1)
		lv.in_window <= 4'h1;
		settle();
		lv.in_window <= 4'h0;
		settle();
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK({rd[10], rd[2]}, 2'b10)
	endtask
	task t_clip;
		axi_wr(CTRL_ADDR, 32'h9, resp);
		lv.clip <= 4'h1;
		settle();
		`CHK({fault_pin_oe, standby_pin_oe}, 2'b01)
		lv.clip <= 4'h3;
		settle();
		`CHK(fault_pin_oe, 1'b1)
		lv.clip <= 4'h0;
		settle();
		`CHK({fault_pin_oe, standby_pin_oe}, 2'b00)
	endtask
	task t_temp;
		lv.warn_hi <= 1'b1;
		settle();
		`CHK(fault_pin_oe, 1'b0)
		lv.warn_lo <= 1'b1;
		settle();
		`CHK(fault_pin_oe, 1'b1)
		`CHK(drive.gain_reduce, 1'b1)
		axi_rd(STAT_ADDR, rd, resp);
		`CHK(rd[7], 1'b1)
		axi_wr(CFG_ADDR, 32'h20, resp);
		settle();
		`CHK(fault_pin_oe, 1'b0)
		// High detector selected: the low one alone no longer warns
		axi_wr(CFG_ADDR, 32'h100, resp);
		lv.warn_hi <= 1'b0;
		settle();
		`CHK(fault_pin_oe, 1'b0)
		axi_wr(CFG_ADDR, 32'h300, resp);
		settle();
		`CHK(fault_pin_oe, 1'b1)
		lv.warn_lo <= 1'b0;
		settle();
		axi_rd(STAT_ADDR, rd, resp);
		axi_rd(STAT_ADDR, rd, resp);
		`CHK(rd[7], 1'b0)
		axi_wr(CFG_ADDR, 32'h0, resp);
	endtask
	task t_load;
		lv.short_flt <= 4'h2;
		settle();
		`CHK(fault_pin_oe, 1'b1)
		axi_wr(CFG_ADDR, 32'h10, resp);
		settle();
		`CHK(fault_pin_oe, 1'b0)
		axi_wr(CFG_ADDR, 32'h210, resp);
		settle();
		`CHK(fault_pin_oe, 1'b1)
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[11], 1'b1)
		lv.short_flt <= 4'h0;
		settle();
		axi_rd(CHAN_ADDR, rd, resp);
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[11], 1'b0)
		axi_wr(CFG_ADDR, 32'h0, resp);
	endtask
	task t_ac;
		axi_wr(CTRL_ADDR, 32'h5, resp);
		pulse(2);
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[4], 1'b0)
		pulse(1);
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[4], 1'b1)
		axi_wr(CTRL_ADDR, 32'h1, resp);
		settle();
		axi_rd(CHAN_ADDR, rd, resp);
		`CHK(rd[4], 1'b1)
	endtask
	task t_head;
		lv.headroom_low <= 1'b1;
		settle();
		`CHK({drive.fast_mute, drive.discharge}, 2'b10)
		repeat (DISCH_CYC) @(posedge aclk);
		settle();
		`CHK(drive.discharge, 1'b1)
		lv.headroom_low <= 1'b0;
		lv.vp_below_mute <= 1'b1;
		lv.disch_done <= 1'b1;
		settle();
		`CHK(drive.amp_on, 1'b0)
		lv.vp_below_mute <= 1'b0;
		settle();
		`CHK(drive.amp_on, 1'b1)
	endtask
	task t_fixed;
		for (i = 0; i < 2; i++)
		begin
			lv.vp_below_mute <= (i == 0);
			lv.vp_over <= (i == 1);
			settle();
			`CHK(fault_pin_oe, 1'b1)
			if (i == 1)
				`CHK(drive.out_hiz, 1'b1)
			lv.vp_below_mute <= 1'b0;
			lv.vp_over <= 1'b0;
			settle();
			`CHK(fault_pin_oe, 1'b0)
		end
	endtask
	// Supply dip below reset: flag set, amplifier waits for start
	task t_supply;
		lv.vp_below_reset <= 1'b1;
		settle();
		`CHK({fault_pin_oe, drive.amp_on}, 2'b10)
		lv.vp_below_reset <= 1'b0;
		settle();
		axi_rd(STAT_ADDR, rd, resp);
		`CHK({rd[4], fault_pin_oe}, 2'b11)
		axi_rd(CTRL_ADDR, rd, resp);
		`CHK(rd[0], 1'b0)
		axi_wr(CTRL_ADDR, 32'h1, resp);
		settle();
		`CHK({fault_pin_oe, drive.amp_on}, 2'b01)
	endtask
	task t_stb;
		standby_pin_in <= 1'b0;
		settle();
		`CHK(drive.fast_mute, 1'b1)
		lv.temp_off <= 1'b1;
		settle();
		`CHK(drive.amp_on, 1'b0)
	endtask
	// ==========================================================
	// Main sequence
	// Gain select is never touched, so never changed unmuted
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, go, burst} = '0;
		s_axi_wstrb = 4'hf;
		standby_pin_in = 1'b1;
		lv = '0;
		lv.startup_done = 1'b1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		t_reset();
		t_start();
		t_ofs();
		t_clip();
		t_temp();
		t_load();
		t_ac();
		t_head();
		t_fixed();
		t_supply();
		t_stb();
		close_out();
	end
	// Watchdog well past the expected few thousand cycles
	initial
	begin
		repeat (30000) @(posedge aclk);
		fails++;
		close_out();
	end
endmodule
